// >>> inc/request_decoder_pkg.sv
package request_decoder_pkg;

  // command words, decimal 6101 and 6111
  localparam logic [15:0] CMD_READ_TABLE = 16'h17d5;
  localparam logic [15:0] CMD_WRITE_TABLE = 16'h17df;

  // memory type codes
  localparam logic [15:0] MEM_REGISTER = 16'h0001;
  localparam logic [15:0] MEM_SCRATCH = 16'h0006;

  // reference map inside register memory
  localparam logic [15:0] FIRST_DATA_REF = 16'h0001;
  localparam logic [15:0] ACC_BASE_REF = 16'h0041;

  // scratch-pad subcommand exchange
  localparam logic [15:0] SCR_CMD_LOC = 16'h0002;
  localparam logic [15:0] SCR_RESULT_LOC = 16'h0004;
  localparam logic [15:0] SUB_ERR_CHECK = 16'h0300;
  localparam logic [15:0] SUB_ERR_LOCATE = 16'h0600;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

  // values after reset
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // target region selected by a request
  typedef enum logic [1:0] {SP_DATA, SP_ACC, SP_SCR} space_t;

  // access kind driven to the target memory port
  localparam logic [1:0] TGT_SPACE_DATA = 2'h0;
  localparam logic [1:0] TGT_SPACE_ACC = 2'h1;

endpackage

// >>> hdl/serial_request_decoder.sv
// Operation
// - command 06101 reads target into host table
// - command 06111 copies host table into target
// - memory type 1 selects register memory
// - start reference 1 is first data register
// - accumulator 0 sits at reference 65
// - data length counts host words, two bytes
// - accumulator length counts one per word
// - sixth word gives first host register
// - read packs low register into low byte
// - write unpacks low byte to lower register
// - 0300 at location 2 starts error check
// - error code appears at location 4
// - 0600 at location 2 starts location check
// - location check returns error user address
// - memory type 6 selects scratch-pad area
// - zero result means no program error
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// first-in first-out buffer between target fetches and host table stores
module request_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  // extra pointer bit tells full from empty; depth must be a power of two
  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    push = in_valid_in && !full;
    pop = out_ready_in && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    in_ready_out = !full;
    out_valid_out = !empty;
    out_data_out = mem[rd_ptr[AW-1:0]];
  end

  // pointers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset, empty flag guards stale words
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// request block decoder with target and host table ports
module serial_request_decoder
  import request_decoder_pkg::*;
#(
  parameter logic [15:0] STATION_ID = 16'h000a,
  parameter int DATA_REGS = 64,
  parameter int ACC_COUNT = 128,
  parameter int SCRATCH_WORDS = 8,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // request block and issue strobe
  input wire logic serial_request_issue_in,
  input wire logic [15:0] req_command_in,
  input wire logic [15:0] req_station_in,
  input wire logic [15:0] req_mem_type_in,
  input wire logic [15:0] req_target_ref_in,
  input wire logic [15:0] req_length_in,
  input wire logic [15:0] req_source_ref_in,
  // request status
  output logic busy_out,
  output logic done_out,
  output logic req_error_out,
  // host register table port
  output logic host_req_out,
  output logic host_we_out,
  output logic [15:0] host_addr_out,
  output logic [15:0] host_wdata_out,
  input wire logic host_ack_in,
  input wire logic [15:0] host_rdata_in,
  // target memory port
  output logic tgt_req_out,
  output logic tgt_we_out,
  output logic [1:0] tgt_space_out,
  output logic [15:0] tgt_addr_out,
  output logic [15:0] tgt_wdata_out,
  input wire logic tgt_ack_in,
  input wire logic [15:0] tgt_rdata_in,
  // user program checker
  input wire logic [15:0] prog_err_code_in,
  input wire logic [15:0] prog_err_loc_in,
  output logic check_start_out,
  output logic prog_error_out
);
  import request_decoder_pkg::*;

  localparam int SW = $clog2(SCRATCH_WORDS);

  typedef enum logic [3:0] {
    ST_IDLE, ST_TGT_RD, ST_PUSH, ST_DRAIN, ST_HOST_RD, ST_TGT_WR, ST_SCR_WR, ST_DONE
  } state_t;

  state_t state, next_state;
  space_t space, next_space;
  logic cmd_write, next_cmd_write, half, next_half, err, next_err;
  logic check, next_check, prog_err, next_prog_err;
  logic [15:0] words_left, next_words_left, tgt_ref, next_tgt_ref;
  logic [15:0] host_addr, next_host_addr, drain_addr, next_drain_addr;
  logic [15:0] word_buf, next_word_buf;
  logic [15:0] scratch [SCRATCH_WORDS];
  logic [15:0] next_scratch [SCRATCH_WORDS];
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [15:0] fifo_out_data;
  logic [17:0] span_end;
  logic bad_req;

  request_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(word_buf),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // request decode, taken only in idle so a busy request is ignored
  always_comb begin
    next_state = state;
    next_space = space;
    next_cmd_write = cmd_write;
    next_half = half;
    next_err = err;
    next_check = 1'b0;
    next_prog_err = prog_err;
    next_words_left = words_left;
    next_tgt_ref = tgt_ref;
    next_host_addr = host_addr;
    next_drain_addr = drain_addr;
    next_word_buf = word_buf;
    next_scratch = scratch;
    span_end = '0;
    bad_req = 1'b0;
    fifo_in_valid = 1'b0;
    // drain runs beside the fetch so a stalled host backs up the fifo
    fifo_pop = fifo_out_valid && host_ack_in && !cmd_write;
    if (fifo_pop) begin
      next_drain_addr = drain_addr + 16'h0001;
    end
    case (state)
      ST_IDLE: begin
        if (serial_request_issue_in) begin
          next_cmd_write = (req_command_in == CMD_WRITE_TABLE);
          bad_req = ((req_command_in != CMD_READ_TABLE) && (req_command_in != CMD_WRITE_TABLE))
                    || (req_station_in != STATION_ID);
          if (req_mem_type_in == MEM_SCRATCH) begin
            // scratch-pad region, one word per location
            next_space = SP_SCR;
            span_end = {2'b00, req_target_ref_in} + {2'b00, req_length_in};
            bad_req = bad_req || (span_end > 18'(SCRATCH_WORDS));
          end else if (req_mem_type_in == MEM_REGISTER) begin
            if (req_target_ref_in >= ACC_BASE_REF) begin
              next_space = SP_ACC;
              span_end = {2'b00, req_target_ref_in - ACC_BASE_REF} + {2'b00, req_length_in};
              bad_req = bad_req || (span_end > 18'(ACC_COUNT));
            end else begin
              // two data registers per host word
              next_space = SP_DATA;
              span_end = {2'b00, req_target_ref_in - FIRST_DATA_REF}
                         + {1'b0, req_length_in, 1'b0};
              bad_req = bad_req || (req_target_ref_in < FIRST_DATA_REF)
                        || (span_end > 18'(DATA_REGS));
            end
          end else begin
            bad_req = 1'b1;
          end
          next_tgt_ref = req_target_ref_in;
          next_words_left = req_length_in;
          // host table start for both directions
          next_host_addr = req_source_ref_in;
          next_drain_addr = req_source_ref_in;
          next_half = 1'b0;
          next_err = bad_req;
          if (bad_req || (req_length_in == WORD_RESET)) begin
            next_state = ST_DONE;
          end else if (req_command_in == CMD_WRITE_TABLE) begin
            next_state = ST_HOST_RD;
          end else begin
            next_state = ST_TGT_RD;
          end
        end
      end
      ST_TGT_RD: begin
        if (space == SP_SCR) begin
          next_word_buf = scratch[tgt_ref[SW-1:0]];
          next_tgt_ref = tgt_ref + 16'h0001;
          next_state = ST_PUSH;
        end else if (tgt_ack_in) begin
          next_tgt_ref = tgt_ref + 16'h0001;
          if (space == SP_ACC) begin
            next_word_buf = tgt_rdata_in;
            next_state = ST_PUSH;
          end else if (!half) begin
            next_word_buf = {word_buf[15:8], tgt_rdata_in[7:0]};
            next_half = 1'b1;
          end else begin
            next_word_buf = {tgt_rdata_in[7:0], word_buf[7:0]};
            next_half = 1'b0;
            next_state = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          next_words_left = words_left - 16'h0001;
          next_state = (words_left == 16'h0001) ? ST_DRAIN : ST_TGT_RD;
        end
      end
      ST_DRAIN: begin
        // finished once the last word has been acknowledged
        if (!fifo_out_valid) begin
          next_state = ST_DONE;
        end
      end
      ST_HOST_RD: begin
        if (host_ack_in) begin
          next_word_buf = host_rdata_in;
          next_host_addr = host_addr + 16'h0001;
          next_state = (space == SP_SCR) ? ST_SCR_WR : ST_TGT_WR;
        end
      end
      ST_TGT_WR: begin
        if (tgt_ack_in) begin
          next_tgt_ref = tgt_ref + 16'h0001;
          if ((space == SP_DATA) && !half) begin
            next_half = 1'b1;
          end else begin
            next_half = 1'b0;
            next_words_left = words_left - 16'h0001;
            next_state = (words_left == 16'h0001) ? ST_DONE : ST_HOST_RD;
          end
        end
      end
      ST_SCR_WR: begin
        next_scratch[tgt_ref[SW-1:0]] = word_buf;
        if (tgt_ref == SCR_CMD_LOC) begin
          if (word_buf == SUB_ERR_CHECK) begin
            next_scratch[SCR_RESULT_LOC[SW-1:0]] = prog_err_code_in;
            next_check = 1'b1;
            next_prog_err = (prog_err_code_in != NO_ERROR_CODE);
          end else if (word_buf == SUB_ERR_LOCATE) begin
            next_scratch[SCR_RESULT_LOC[SW-1:0]] = prog_err_loc_in;
            next_check = 1'b1;
          end
        end
        next_tgt_ref = tgt_ref + 16'h0001;
        next_words_left = words_left - 16'h0001;
        next_state = (words_left == 16'h0001) ? ST_DONE : ST_HOST_RD;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      space <= SP_DATA;
      cmd_write <= 1'b0;
      half <= 1'b0;
      err <= 1'b0;
      check <= 1'b0;
      prog_err <= 1'b0;
      words_left <= WORD_RESET;
      tgt_ref <= WORD_RESET;
      host_addr <= WORD_RESET;
      drain_addr <= WORD_RESET;
      word_buf <= WORD_RESET;
      for (int i = 0; i < SCRATCH_WORDS; i++) begin
        scratch[i] <= WORD_RESET;
      end
    end else begin
      state <= next_state;
      space <= next_space;
      cmd_write <= next_cmd_write;
      half <= next_half;
      err <= next_err;
      check <= next_check;
      prog_err <= next_prog_err;
      words_left <= next_words_left;
      tgt_ref <= next_tgt_ref;
      host_addr <= next_host_addr;
      drain_addr <= next_drain_addr;
      word_buf <= next_word_buf;
      scratch <= next_scratch;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port drive; handshakes from state and fifo occupancy, data from registers or fifo storage
  always_comb begin
    busy_out = (state != ST_IDLE);
    done_out = (state == ST_DONE);
    req_error_out = err;
    check_start_out = check;
    prog_error_out = prog_err;
    host_req_out = (state == ST_HOST_RD) || (fifo_out_valid && !cmd_write);
    host_we_out = !cmd_write;
    host_addr_out = cmd_write ? host_addr : drain_addr;
    host_wdata_out = fifo_out_data;
    tgt_req_out = ((state == ST_TGT_RD) || (state == ST_TGT_WR)) && (space != SP_SCR);
    tgt_we_out = (state == ST_TGT_WR);
    tgt_space_out = (space == SP_ACC) ? TGT_SPACE_ACC : TGT_SPACE_DATA;
    tgt_addr_out = (space == SP_ACC) ? tgt_ref - ACC_BASE_REF : tgt_ref - FIRST_DATA_REF;
    // low byte first, high byte to next register
    if (space == SP_ACC) begin
      tgt_wdata_out = word_buf;
    end else begin
      tgt_wdata_out = {8'h00, half ? word_buf[15:8] : word_buf[7:0]};
    end
  end
endmodule

`default_nettype wire

// >>> dv/serial_request_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// pin-level checks on the request decoder
module decoder_props
  import request_decoder_pkg::*;
#(
  parameter logic [15:0] STATION_ID = 16'h000a
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // request block
  input wire logic serial_request_issue_in,
  input wire logic [15:0] req_command_in,
  input wire logic [15:0] req_station_in,
  input wire logic [15:0] req_mem_type_in,
  // status
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic req_error_out,
  input wire logic check_start_out,
  // memory ports
  input wire logic host_req_out,
  input wire logic [15:0] host_addr_out,
  input wire logic host_ack_in,
  input wire logic tgt_req_out,
  input wire logic tgt_we_out,
  input wire logic [1:0] tgt_space_out,
  input wire logic [15:0] tgt_addr_out,
  input wire logic [15:0] tgt_wdata_out,
  input wire logic tgt_ack_in
);
  import request_decoder_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic take;
  logic bad_cmd;
  logic bad_stn;
  logic bad_type;
  // decode of an accepted block, refused fields split out
  assign take = serial_request_issue_in && !busy_out;
  assign bad_cmd = req_command_in != CMD_READ_TABLE && req_command_in != CMD_WRITE_TABLE;
  assign bad_stn = req_station_in != STATION_ID;
  assign bad_type = req_mem_type_in != MEM_REGISTER && req_mem_type_in != MEM_SCRATCH;

  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done held longer than one cycle");
  busy_rise_a: assert property (take |=> busy_out)
    else $error("busy not raised after issue");
  bad_cmd_a: assert property (take && bad_cmd |-> ##[1:2] (done_out && req_error_out))
    else $error("unknown command not refused");
  bad_station_a: assert property (take && bad_stn |-> ##[1:2] (done_out && req_error_out))
    else $error("foreign station not refused");
  bad_type_a: assert property (take && bad_type |-> ##[1:2] (done_out && req_error_out))
    else $error("unknown memory type not refused");
  reject_quiet_a: assert property (take && (bad_cmd || bad_stn || bad_type)
    |=> (!tgt_req_out && !host_req_out) [*2])
    else $error("refused request touched memory");
  tgt_hold_a: assert property (tgt_req_out && !tgt_ack_in
    |=> tgt_req_out && $stable(tgt_addr_out) && $stable(tgt_wdata_out))
    else $error("target request dropped or changed before ack");
  host_hold_a: assert property (host_req_out && !host_ack_in
    |=> host_req_out && $stable(host_addr_out))
    else $error("host request dropped or changed before ack");
  byte_clear_a: assert property (tgt_req_out && tgt_we_out && tgt_space_out == TGT_SPACE_DATA
    |-> tgt_wdata_out[15:8] == 8'h00)
    else $error("data register write carries a high byte");
  check_done_a: assert property (check_start_out |-> done_out && !req_error_out)
    else $error("check start outside a good completion");
  idle_quiet_a: assert property (!busy_out |-> !tgt_req_out && !host_req_out)
    else $error("memory request while idle");

  // main scenarios reached
  cover property (check_start_out);
  cover property (done_out && req_error_out);
  cover property ((host_req_out && !host_ack_in) [*4]);
endmodule

bind serial_request_decoder decoder_props #(.STATION_ID(STATION_ID)) props_i (
  .clk_in, .rstn_in, .serial_request_issue_in, .req_command_in, .req_station_in,
  .req_mem_type_in, .busy_out, .done_out, .req_error_out, .check_start_out,
  .host_req_out, .host_addr_out, .host_ack_in, .tgt_req_out, .tgt_we_out,
  .tgt_space_out, .tgt_addr_out, .tgt_wdata_out, .tgt_ack_in);
`default_nettype wire

// >>> dv/table_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// host register table and target memories, ack after a set wait
module table_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] host_wait_in,
  input wire logic host_req_in,
  input wire logic host_we_in,
  input wire logic [15:0] host_addr_in,
  input wire logic [15:0] host_wdata_in,
  output logic host_ack_out,
  output logic [15:0] host_rdata_out,
  input wire logic tgt_req_in,
  input wire logic tgt_we_in,
  input wire logic [1:0] tgt_space_in,
  input wire logic [15:0] tgt_addr_in,
  input wire logic [15:0] tgt_wdata_in,
  output logic tgt_ack_out,
  output logic [15:0] tgt_rdata_out
);
  logic [15:0] host_mem [0:63];
  logic [7:0] tgt_data [0:63];
  logic [15:0] tgt_acc [0:127];
  logic [7:0] hcnt;
  // host table: stalls host_wait_in cycles, scrambles data when not answering
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hcnt <= 8'h00;
      host_ack_out <= 1'b0;
      host_rdata_out <= 16'h5a5a;
    end else begin
      host_ack_out <= 1'b0;
      host_rdata_out <= ~host_rdata_out;
      if (host_req_in && !host_ack_out && hcnt < host_wait_in) begin
        hcnt <= hcnt + 8'h01;
      end else if (host_req_in && !host_ack_out) begin
        hcnt <= 8'h00;
        host_ack_out <= 1'b1;
        if (host_we_in) host_mem[host_addr_in[5:0]] <= host_wdata_in;
        else host_rdata_out <= host_mem[host_addr_in[5:0]];
      end
    end
  end
  // target: bytes in data space, whole words for accumulators
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tgt_ack_out <= 1'b0;
      tgt_rdata_out <= 16'ha5a5;
    end else begin
      tgt_ack_out <= tgt_req_in && !tgt_ack_out;
      tgt_rdata_out <= ~tgt_rdata_out;
      if (tgt_req_in && !tgt_ack_out) begin
        if (tgt_space_in == 2'h0 && tgt_we_in) tgt_data[tgt_addr_in[5:0]] <= tgt_wdata_in[7:0];
        if (tgt_space_in == 2'h0 && !tgt_we_in) tgt_rdata_out <= {8'h00, tgt_data[tgt_addr_in[5:0]]};
        if (tgt_space_in == 2'h1 && tgt_we_in) tgt_acc[tgt_addr_in[6:0]] <= tgt_wdata_in;
        if (tgt_space_in == 2'h1 && !tgt_we_in) tgt_rdata_out <= tgt_acc[tgt_addr_in[6:0]];
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/serial_request_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module serial_request_decoder_tb_top;
  import request_decoder_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic iss = 1'b0;
  logic [15:0] w [0:5] = '{default: 16'h0000};
  logic [15:0] code = 16'h0000;
  logic [15:0] loc = 16'h0000;
  logic [7:0] hw = 8'h00;
  logic [15:0] src = 16'h0000;
  logic busy_out, done_out, req_error_out, host_req_out, host_we_out, host_ack_in;
  logic tgt_req_out, tgt_we_out, tgt_ack_in, check_start_out, prog_error_out;
  logic [15:0] host_addr_out, host_wdata_out, host_rdata_in, tgt_addr_out, tgt_wdata_out;
  logic [15:0] tgt_rdata_in;
  logic [1:0] tgt_space_out;
  logic [31:0] hq [$];
  logic [1:0] eq [$];
  logic [15:0] acc [0:19];
  int err_total = 0;
  int total_checks = 0;
  int k;
  always #4 clk_in = ~clk_in;

  serial_request_decoder dut (.clk_in, .rstn_in, .serial_request_issue_in(iss),
    .req_command_in(w[0]), .req_station_in(w[1]), .req_mem_type_in(w[2]),
    .req_target_ref_in(w[3]), .req_length_in(w[4]), .req_source_ref_in(w[5]),
    .busy_out, .done_out, .req_error_out, .host_req_out, .host_we_out, .host_addr_out,
    .host_wdata_out, .host_ack_in, .host_rdata_in, .tgt_req_out, .tgt_we_out,
    .tgt_space_out, .tgt_addr_out, .tgt_wdata_out, .tgt_ack_in, .tgt_rdata_in,
    .prog_err_code_in(code), .prog_err_loc_in(loc), .check_start_out, .prog_error_out);
  table_model pm (.clk_in, .rstn_in, .host_wait_in(hw), .host_req_in(host_req_out),
    .host_we_in(host_we_out), .host_addr_in(host_addr_out), .host_wdata_in(host_wdata_out),
    .host_ack_out(host_ack_in), .host_rdata_out(host_rdata_in), .tgt_req_in(tgt_req_out),
    .tgt_we_in(tgt_we_out), .tgt_space_in(tgt_space_out), .tgt_addr_in(tgt_addr_out),
    .tgt_wdata_in(tgt_wdata_out), .tgt_ack_out(tgt_ack_in), .tgt_rdata_out(tgt_rdata_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request block; strobe held only in its issue cycle, words left in place, then a bounded wait for done
  task automatic issue(input logic [15:0] c, r, l, s, input logic [15:0] t = MEM_REGISTER,
                       input logic [15:0] st = 16'h000a); // target station word
    int n;
    w = '{c, st, t, r, l, s};
    iss = 1'b1;
    @(posedge clk_in);
    #1 iss = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 3000) begin
      err_total++;
      conclude();
    end else begin
      // let the done cycle pass, an issue during it is dropped
      @(posedge clk_in);
      #1;
    end
  endtask

  // watcher: host stores and completions against the oldest note
  always @(posedge clk_in) begin
    if (host_req_out && host_we_out && host_ack_in) begin
      if (hq.size() == 0) check(32'h0, 32'h1);
      else check({host_addr_out, host_wdata_out}, hq.pop_front());
    end
    if (done_out === 1'b1) begin
      if (eq.size() == 0) check(32'h0, 32'h1);
      else check({req_error_out, check_start_out}, eq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h96bd));
    for (k = 0; k < 64; k++) pm.host_mem[k] = $urandom;
    for (k = 0; k < 20; k++) acc[k] = $urandom;
    for (k = 0; k < 20; k++) pm.tgt_acc[k] = acc[k];
    repeat (20) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    // write four byte registers from two host words, then read them back
    eq.push_back(2'b00);
    issue(CMD_WRITE_TABLE, 16'h0001, 16'h0002, 16'h0001);
    for (k = 0; k < 4; k++) check(pm.tgt_data[k], 32'(pm.host_mem[1 + k / 2][8 * (k % 2) +: 8]));
    eq.push_back(2'b00);
    hq.push_back({16'h000a, pm.host_mem[1]});
    hq.push_back({16'h000b, pm.host_mem[2]});
    issue(CMD_READ_TABLE, 16'h0001, 16'h0002, 16'h000a);
    // twenty accumulators through a stalled host table, fifo fills
    hw = 8'($urandom_range(40, 20));
    src = 16'($urandom_range(40, 16));
    eq.push_back(2'b00);
    for (k = 0; k < 20; k++) hq.push_back({src + 16'(k), acc[k]});
    issue(CMD_READ_TABLE, ACC_BASE_REF, 16'd20, src);
    hw = 8'h02;
    eq.push_back(2'b00);
    issue(CMD_WRITE_TABLE, 16'd66, 16'd1, 16'd3);
    check(pm.tgt_acc[1], pm.host_mem[3]);
    // error check with a nonzero code, then zero, then location check
    pm.host_mem[5] = SUB_ERR_CHECK;
    pm.host_mem[7] = SUB_ERR_LOCATE;
    for (k = 0; k < 3; k++) begin
      code = (k == 0) ? (16'($urandom) | 16'h0001) : 16'h0000;
      loc = 16'($urandom);
      eq.push_back(2'b01);
      issue(CMD_WRITE_TABLE, SCR_CMD_LOC, 16'd1, (k == 2) ? 16'd7 : 16'd5, MEM_SCRATCH);
      if (k < 2) check(prog_error_out, k == 0);
      eq.push_back(2'b00);
      hq.push_back({16'd6, (k == 2) ? loc : code});
      issue(CMD_READ_TABLE, SCR_RESULT_LOC, 16'd1, 16'd6, MEM_SCRATCH);
    end
    // refused blocks: command, station, type, data span, zero reference
    for (k = 0; k < 5; k++) begin
      eq.push_back(2'b10);
      issue((k == 0) ? 16'h17d6 : CMD_READ_TABLE, (k == 4) ? 16'd0 : 16'd1,
            (k == 3) ? 16'd33 : 16'd1, 16'd1, (k == 2) ? 16'd3 : MEM_REGISTER,
            (k == 1) ? 16'd2 : 16'h000a);
    end
    check(hq.size() + eq.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
